// ===== rtl/iod_pkg.sv
package iod_pkg;

  // ==========================================================
  // Address spaces
  // ==========================================================
  localparam int         IO_ADDR_W    = 6;      // 64 locations for in/out
  localparam logic [7:0] IO_DS_OFFSET = 8'h20;  // I/O address to data address
  localparam logic [7:0] BIT_IO_LAST  = 8'h1F;  // Last bit-addressable I/O location
  localparam logic [7:0] REG_RST      = 8'h00;  // Reset value of every register

  // ==========================================================
  // Register data addresses
  // ==========================================================
  localparam logic [7:0] ADR_PA_PINS  = 8'h20;
  localparam logic [7:0] ADR_PA_DIR   = 8'h21;
  localparam logic [7:0] ADR_PA_OUT   = 8'h22;
  localparam logic [7:0] ADR_PB_PINS  = 8'h23;
  localparam logic [7:0] ADR_PB_DIR   = 8'h24;
  localparam logic [7:0] ADR_PB_OUT   = 8'h25;
  localparam logic [7:0] ADR_PC_OUT   = 8'h28;
  localparam logic [7:0] ADR_PD_PINS  = 8'h29;
  localparam logic [7:0] ADR_PD_DIR   = 8'h2A;
  localparam logic [7:0] ADR_PD_OUT   = 8'h2B;
  localparam logic [7:0] ADR_T0_FLG   = 8'h35;
  localparam logic [7:0] ADR_T1_FLG   = 8'h36;
  localparam logic [7:0] ADR_PC_FLG   = 8'h3B;
  localparam logic [7:0] ADR_EXT_FLG  = 8'h3C;
  localparam logic [7:0] ADR_EXT_MSK  = 8'h3D;
  localparam logic [7:0] ADR_SCR0     = 8'h3E;
  localparam logic [7:0] ADR_EE_CTL   = 8'h3F;
  localparam logic [7:0] ADR_EE_DATA  = 8'h40;
  localparam logic [7:0] ADR_EE_ADRL  = 8'h41;
  localparam logic [7:0] ADR_EE_ADRH  = 8'h42;
  localparam logic [7:0] ADR_PRESC    = 8'h43;
  localparam logic [7:0] ADR_T0_CTLA  = 8'h44;
  localparam logic [7:0] ADR_T0_CTLB  = 8'h45;
  localparam logic [7:0] ADR_T0_CNT   = 8'h46;
  localparam logic [7:0] ADR_T0_CMPA  = 8'h47;
  localparam logic [7:0] ADR_T0_CMPB  = 8'h48;
  localparam logic [7:0] ADR_SCR1     = 8'h4A;
  localparam logic [7:0] ADR_SCR2     = 8'h4B;
  localparam logic [7:0] ADR_DBG      = 8'h51;
  localparam logic [7:0] ADR_SLEEP    = 8'h53;
  localparam logic [7:0] ADR_RST_CAUS = 8'h54;
  localparam logic [7:0] ADR_CORE_CTL = 8'h55;
  localparam logic [7:0] ADR_SELF_PRG = 8'h57;
  localparam logic [7:0] ADR_SP_LO    = 8'h5D;
  localparam logic [7:0] ADR_SP_HI    = 8'h5E;
  localparam logic [7:0] ADR_CORE_FLG = 8'h5F;
  localparam logic [7:0] ADR_WDOG     = 8'h60;
  localparam logic [7:0] ADR_WAKE     = 8'h62;
  localparam logic [7:0] ADR_PWR_RED  = 8'h64;
  localparam logic [7:0] ADR_OSC_CAL  = 8'h66;
  localparam logic [7:0] ADR_PCI_CTL  = 8'h68;
  localparam logic [7:0] ADR_EXT_SNS  = 8'h69;
  localparam logic [7:0] ADR_PC_MSK0  = 8'h6B;
  localparam logic [7:0] ADR_PC_MSK1  = 8'h6C;
  localparam logic [7:0] ADR_T0_IMSK  = 8'h6E;
  localparam logic [7:0] ADR_T1_IMSK  = 8'h6F;
  localparam logic [7:0] ADR_VRES_LO  = 8'h78;
  localparam logic [7:0] ADR_VRES_HI  = 8'h79;
  localparam logic [7:0] ADR_T1_CNTL  = 8'h84;
  localparam logic [7:0] ADR_T1_CNTH  = 8'h85;
  localparam logic [7:0] ADR_T1_CMPL  = 8'h88;
  localparam logic [7:0] ADR_T1_CMPH  = 8'h89;
  localparam logic [7:0] ADR_TW_RATE  = 8'hB8;
  localparam logic [7:0] ADR_TW_DATA  = 8'hBB;

  // ==========================================================
  // Implemented bits per address
  // ==========================================================
  // Bits that software stores; everything else is reserved, apart from flags and read-only inputs
  function automatic logic [7:0] rw_mask(input logic [7:0] a);
    case (a)
      ADR_PC_OUT, ADR_EE_ADRH:                          rw_mask = 8'h01;
      ADR_PD_DIR, ADR_PD_OUT, ADR_PCI_CTL, ADR_T1_IMSK: rw_mask = 8'h03;
      ADR_T0_IMSK:                                      rw_mask = 8'h07;
      ADR_EXT_MSK, ADR_SLEEP, ADR_PWR_RED:              rw_mask = 8'h0F;
      ADR_RST_CAUS:                                     rw_mask = 8'h1F;
      ADR_EE_CTL:                                       rw_mask = 8'h3F;
      ADR_PRESC:                                        rw_mask = 8'h81;
      ADR_CORE_CTL:                                     rw_mask = 8'h93;
      ADR_T0_CTLB:                                      rw_mask = 8'hCF;
      ADR_T0_CTLA:                                      rw_mask = 8'hF3;
      ADR_PA_DIR, ADR_PA_OUT, ADR_PB_DIR, ADR_PB_OUT, ADR_SCR0, ADR_EE_DATA,
      ADR_EE_ADRL, ADR_T0_CNT, ADR_T0_CMPA, ADR_T0_CMPB, ADR_SCR1, ADR_SCR2,
      ADR_DBG, ADR_SELF_PRG, ADR_SP_LO, ADR_SP_HI, ADR_CORE_FLG, ADR_WDOG,
      ADR_WAKE, ADR_OSC_CAL, ADR_EXT_SNS, ADR_PC_MSK0, ADR_PC_MSK1,
      ADR_T1_CMPL, ADR_T1_CMPH, ADR_TW_RATE, ADR_TW_DATA:  rw_mask = 8'hFF;
      default:                                          rw_mask = 8'h00;
    endcase
  endfunction

  // Flags set by hardware and cleared by writing one
  function automatic logic [7:0] w1c_mask(input logic [7:0] a);
    case (a)
      ADR_T0_FLG:  w1c_mask = 8'h07;
      ADR_T1_FLG:  w1c_mask = 8'h03;
      ADR_PC_FLG:  w1c_mask = 8'h03;
      ADR_EXT_FLG: w1c_mask = 8'h0F;
      default:     w1c_mask = 8'h00;
    endcase
  endfunction

endpackage

// ===== rtl/iod_io_space.sv
`timescale 1ns/1ps
// How it works
// - Bit set and clear act only on I/O locations 0x00 to 0x1F.
// - Bit-skip tests can test any bit of the lowest 32 locations.
// - Some flags clear on writing one; writing zero leaves them alone.
// - Bit set/clear rewrites whole register, so other set flags get cleared.
// - In and out instructions reach only I/O locations 0x00 to 0x3F.
// - Data address of an I/O register equals its I/O address plus 0x20.
// - Area 0x60 to 0xFF is reachable only by load and store.
// - Second timer compare: high byte at 0x89, low byte at 0x88.
// - Second timer count: high byte at 0x85, low byte at 0x84.
// - First timer count at 0x46, compares A and B at 0x47, 0x48.
// - Voltage result low byte 0x78, high byte 0x79, high bits 7:4 reserved.
// - EEPROM data 0x40, address low 0x41, high 0x42 with bit 0 only.
// - Two-wire data register at 0xBB, bit-rate register at 0xB8.
// - Debug register at 0x51, scratch registers at 0x3E, 0x4A, 0x4B.
module iod_io_space
  import iod_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // Load and store access in data space
  input  wire logic [7:0]           ds_addr_in,
  input  wire logic                 ds_rd_in,
  input  wire logic                 ds_wr_in,
  input  wire logic [7:0]           ds_wdata_in,
  // In and out access in I/O space
  input  wire logic [IO_ADDR_W-1:0] io_addr_in,
  input  wire logic                 io_rd_in,
  input  wire logic                 io_wr_in,
  input  wire logic [7:0]           io_wdata_in,
  // Single-bit operations on I/O space
  input  wire logic                 set_io_bit_instr_in,
  input  wire logic                 clear_io_bit_instr_in,
  input  wire logic                 skip_if_io_bit_high_in,
  input  wire logic                 skip_if_io_bit_low_in,
  input  wire logic [2:0]           bit_sel_in,
  // Read answers
  output logic [7:0]                rd_data_out,
  output logic                      rd_valid_out,
  output logic                      skip_out,
  output logic                      skip_valid_out,
  // Port pins, asynchronous to clk_in
  input  wire logic [7:0]           port_a_pins_in,
  input  wire logic [7:0]           port_b_pins_in,
  input  wire logic [1:0]           port_d_pins_in,
  // Peripheral events and status, same clock
  input  wire logic [2:0]           timer0_flag_set_in,
  input  wire logic [1:0]           timer1_flag_set_in,
  input  wire logic [1:0]           pin_change_flag_set_in,
  input  wire logic [3:0]           external_int_flag_set_in,
  input  wire logic [15:0]          timer1_count_in,
  input  wire logic [11:0]          voltage_converter_result_in,
  // Register contents toward the peripherals
  output logic [7:0]                port_a_output_out,
  output logic [7:0]                port_a_direction_out,
  output logic [7:0]                port_b_output_out,
  output logic [7:0]                port_b_direction_out,
  output logic                      port_c_output_out,
  output logic [1:0]                port_d_output_out,
  output logic [1:0]                port_d_direction_out,
  output logic [3:0]                external_int_mask_out,
  output logic [7:0]                timer0_count_out,
  output logic [7:0]                timer0_compare_a_out,
  output logic [7:0]                timer0_compare_b_out,
  output logic [15:0]               timer1_compare_out,
  output logic [8:0]                eeprom_address_out,
  output logic [7:0]                eeprom_data_out,
  output logic [7:0]                debug_channel_out,
  output logic [7:0]                two_wire_data_reg_out,
  output logic [7:0]                two_wire_rate_reg_out
);

  // ==========================================================
  // Storage and per-address views
  // ==========================================================
  logic [7:0] reg_r    [0:255];
  logic [7:0] reg_nxt  [0:255];
  logic [7:0] stored_m [0:255];
  logic [7:0] set_vec  [0:255];
  logic [7:0] ro_vec   [0:255];

  // Pin synchronisers
  logic [7:0] pa_meta_r;
  logic [7:0] pa_sync_r;
  logic [7:0] pb_meta_r;
  logic [7:0] pb_sync_r;
  logic [1:0] pd_meta_r;
  logic [1:0] pd_sync_r;

  // Answer registers
  logic [7:0] rd_data_r;
  logic       rd_valid_r;
  logic       skip_r;
  logic       skip_valid_r;

  // Decode wires
  logic       ds_acc_w;
  logic       io_sel_w;
  logic [7:0] io_ds_addr_w;
  logic [7:0] acc_addr_w;
  logic       bit_range_w;
  logic       bit_rmw_w;
  logic       bit_test_w;
  logic [7:0] bit_msk_w;
  logic [7:0] rd_val_w;
  logic       wr_en_w;
  logic [7:0] wdata_w;
  logic       rd_en_w;

  // ==========================================================
  // Pin input synchronisers
  // ==========================================================
  // Two stages; only the second stage is read anywhere
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pa_meta_r <= REG_RST;
      pa_sync_r <= REG_RST;
      pb_meta_r <= REG_RST;
      pb_sync_r <= REG_RST;
      pd_meta_r <= 2'h0;
      pd_sync_r <= 2'h0;
    end
    else
    begin
      pa_meta_r <= port_a_pins_in;
      pa_sync_r <= pa_meta_r;
      pb_meta_r <= port_b_pins_in;
      pb_sync_r <= pb_meta_r;
      pd_meta_r <= port_d_pins_in;
      pd_sync_r <= pd_meta_r;
    end
  end

  // ==========================================================
  // Access decode
  // ==========================================================
  // Load/store wins over I/O-space ops in the same cycle
  assign ds_acc_w     = ds_rd_in | ds_wr_in;
  assign io_sel_w     = ~ds_acc_w;
  // A 6-bit I/O address can never reach 0x60 and up
  assign io_ds_addr_w = {2'b00, io_addr_in} + IO_DS_OFFSET;
  assign acc_addr_w   = ds_acc_w ? ds_addr_in : io_ds_addr_w;
  // Bit ops only below 0x20 in I/O space
  assign bit_range_w  = ({2'b00, io_addr_in} <= BIT_IO_LAST);
  assign bit_rmw_w    = io_sel_w & bit_range_w
                      & (set_io_bit_instr_in | clear_io_bit_instr_in);
  assign bit_test_w   = io_sel_w & bit_range_w
                      & (skip_if_io_bit_high_in | skip_if_io_bit_low_in);
  assign bit_msk_w    = 8'h01 << bit_sel_in;

  // Current value of the addressed location; reserved reads zero
  assign rd_val_w = stored_m[acc_addr_w] | ro_vec[acc_addr_w];

  // One write port shared by store, out and bit read-modify-write
  assign wr_en_w = ds_wr_in | (io_sel_w & io_wr_in) | bit_rmw_w;
  assign rd_en_w = ds_rd_in | (io_sel_w & io_rd_in);

  // Bit ops write back the whole current value, flags included
  always_comb
  begin
    if (ds_wr_in)
      wdata_w = ds_wdata_in;
    else if (io_wr_in)
      wdata_w = io_wdata_in;
    else if (set_io_bit_instr_in)
      wdata_w = rd_val_w | bit_msk_w;
    else
      wdata_w = rd_val_w & ~bit_msk_w;
  end

  // ==========================================================
  // Hardware-driven contents
  // ==========================================================
  // Flag set events, per address
  always_comb
  begin
    for (int i = 0; i < 256; i++)
      set_vec[i] = REG_RST;
    set_vec[ADR_T0_FLG]  = {5'h00, timer0_flag_set_in};
    set_vec[ADR_T1_FLG]  = {6'h00, timer1_flag_set_in};
    set_vec[ADR_PC_FLG]  = {6'h00, pin_change_flag_set_in};
    set_vec[ADR_EXT_FLG] = {4'h0, external_int_flag_set_in};
  end

  // Read-only locations driven from outside the register bank
  always_comb
  begin
    for (int i = 0; i < 256; i++)
      ro_vec[i] = REG_RST;
    ro_vec[ADR_PA_PINS] = pa_sync_r;
    ro_vec[ADR_PB_PINS] = pb_sync_r;
    ro_vec[ADR_PD_PINS] = {6'h00, pd_sync_r};
    ro_vec[ADR_T1_CNTL] = timer1_count_in[7:0];
    ro_vec[ADR_T1_CNTH] = timer1_count_in[15:8];
    ro_vec[ADR_VRES_LO] = voltage_converter_result_in[7:0];
    ro_vec[ADR_VRES_HI] = {4'h0, voltage_converter_result_in[11:8]};
  end

  // ==========================================================
  // Register bank
  // ==========================================================
  // Masks prune every reserved bit to a constant zero
  for (genvar a = 0; a < 256; a++)
  begin : g_reg
    localparam logic [7:0] RWM = rw_mask(8'(a));
    localparam logic [7:0] W1M = w1c_mask(8'(a));
    logic hit_w;

    assign hit_w = wr_en_w & (acc_addr_w == 8'(a));

    // A flag event in the clearing cycle still sets the flag
    assign reg_nxt[a] = hit_w
      ? ((wdata_w & RWM) | (reg_r[a] & W1M & ~wdata_w) | (set_vec[a] & W1M))
      : ((reg_r[a] & RWM) | ((reg_r[a] | set_vec[a]) & W1M));
    assign stored_m[a] = reg_r[a] & (RWM | W1M);

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
        reg_r[a] <= REG_RST;
      else
        reg_r[a] <= reg_nxt[a];
    end
  end

  // ==========================================================
  // Read and skip answers
  // ==========================================================
  // Answers come one cycle after the request
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_data_r    <= REG_RST;
      rd_valid_r   <= 1'b0;
      skip_r       <= 1'b0;
      skip_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r   <= rd_en_w;
      skip_valid_r <= bit_test_w;
      if (rd_en_w)
        rd_data_r <= rd_val_w;
      if (bit_test_w)
        skip_r <= skip_if_io_bit_high_in ? rd_val_w[bit_sel_in] : ~rd_val_w[bit_sel_in];
    end
  end

  assign rd_data_out    = rd_data_r;
  assign rd_valid_out   = rd_valid_r;
  assign skip_out       = skip_r;
  assign skip_valid_out = skip_valid_r;

  // ==========================================================
  // Register outputs
  // ==========================================================
  // Direct taps on the flip-flops of the bank
  assign port_a_output_out     = reg_r[ADR_PA_OUT];
  assign port_a_direction_out  = reg_r[ADR_PA_DIR];
  assign port_b_output_out     = reg_r[ADR_PB_OUT];
  assign port_b_direction_out  = reg_r[ADR_PB_DIR];
  assign port_c_output_out     = reg_r[ADR_PC_OUT][0];
  assign port_d_output_out     = reg_r[ADR_PD_OUT][1:0];
  assign port_d_direction_out  = reg_r[ADR_PD_DIR][1:0];
  assign external_int_mask_out = reg_r[ADR_EXT_MSK][3:0];
  assign timer0_count_out      = reg_r[ADR_T0_CNT];
  assign timer0_compare_a_out  = reg_r[ADR_T0_CMPA];
  assign timer0_compare_b_out  = reg_r[ADR_T0_CMPB];
  assign timer1_compare_out    = {reg_r[ADR_T1_CMPH], reg_r[ADR_T1_CMPL]};
  assign eeprom_address_out    = {reg_r[ADR_EE_ADRH][0], reg_r[ADR_EE_ADRL]};
  assign eeprom_data_out       = reg_r[ADR_EE_DATA];
  assign debug_channel_out     = reg_r[ADR_DBG];
  assign two_wire_data_reg_out = reg_r[ADR_TW_DATA];
  assign two_wire_rate_reg_out = reg_r[ADR_TW_RATE];

endmodule

// ===== dv/iod_io_space_chk.sv
`timescale 1ns/1ps
// ==================================================
// Port checks for the I/O space decoder
// ==================================================
module iod_io_space_chk
  import iod_pkg::*;
(
  // Clock and reset
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  // Requests
  input wire logic [7:0]           ds_addr_in,
  input wire logic                 ds_rd_in,
  input wire logic                 ds_wr_in,
  input wire logic [7:0]           ds_wdata_in,
  input wire logic [IO_ADDR_W-1:0] io_addr_in,
  input wire logic                 io_rd_in,
  input wire logic                 io_wr_in,
  input wire logic [7:0]           io_wdata_in,
  input wire logic                 set_io_bit_instr_in,
  input wire logic                 clear_io_bit_instr_in,
  input wire logic                 skip_if_io_bit_high_in,
  input wire logic                 skip_if_io_bit_low_in,
  // Answers and register contents
  input wire logic                 rd_valid_out,
  input wire logic                 skip_valid_out,
  input wire logic [7:0]           port_a_output_out,
  input wire logic [7:0]           timer0_compare_a_out,
  input wire logic [15:0]          timer1_compare_out,
  input wire logic [8:0]           eeprom_address_out,
  input wire logic [7:0]           debug_channel_out,
  input wire logic [7:0]           two_wire_data_reg_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Data-space cycles shadow I/O-space requests
  wire ds_busy  = ds_rd_in | ds_wr_in;
  wire rd_any   = ds_rd_in | io_rd_in;
  wire skip_req = (skip_if_io_bit_high_in | skip_if_io_bit_low_in) & ~ds_busy;
  wire bit_wr   = (set_io_bit_instr_in | clear_io_bit_instr_in) & ~ds_busy & ~io_wr_in;

  sequence store_s(a);
    ds_wr_in && ds_addr_in == a;
  endsequence
  sequence load_s;
    ds_rd_in || (io_rd_in && !ds_wr_in);
  endsequence

  rd_answer_a: assert property (load_s |=> rd_valid_out)
    else $error("read gave no answer pulse");
  rd_cause_a: assert property (rd_valid_out |-> $past(rd_any))
    else $error("answer pulse without a read");
  skip_low_a: assert property (skip_req && !io_addr_in[5] |=> skip_valid_out)
    else $error("bit test in low area not answered");
  skip_high_a: assert property (skip_req && io_addr_in[5] |=> !skip_valid_out)
    else $error("bit test above low area answered");
  cmp0a_store_a: assert property (store_s(ADR_T0_CMPA) |=> timer0_compare_a_out == $past(ds_wdata_in))
    else $error("first timer compare A not stored");
  cmp1_high_a: assert property (store_s(ADR_T1_CMPH) |=> timer1_compare_out[15:8] == $past(ds_wdata_in))
    else $error("timer1 compare high byte not stored");
  tw_data_a: assert property (store_s(ADR_TW_DATA) |=> two_wire_data_reg_out == $past(ds_wdata_in))
    else $error("two-wire data not stored");
  io_offset_a: assert property (io_wr_in && !ds_busy && io_addr_in == 6'h02
    |=> port_a_output_out == $past(io_wdata_in))
    else $error("out to I/O 0x02 missed data 0x22");
  bit_range_a: assert property (bit_wr && io_addr_in == 6'h22 |=> $stable(eeprom_address_out))
    else $error("bit op above 0x1F changed a register");
  dbg_hold_a: assert property (!(ds_wr_in && ds_addr_in == ADR_DBG) && !(io_wr_in && io_addr_in == 6'h31)
    |=> $stable(debug_channel_out))
    else $error("debug register moved without a write");
endmodule

bind iod_io_space iod_io_space_chk chk_u (.*);

// ===== dv/iod_cpu_model.sv
`timescale 1ns/1ps
// ==================================================
// CPU side: one access, then an idle cycle
// ==================================================
module iod_cpu_model
  import iod_pkg::*;
(
  // Clock
  input  wire logic                 clk_in,
  // Requests
  output logic [7:0]                ds_addr_out,
  output logic                      ds_rd_out,
  output logic                      ds_wr_out,
  output logic [7:0]                ds_wdata_out,
  output logic [IO_ADDR_W-1:0]      io_addr_out,
  output logic                      io_rd_out,
  output logic                      io_wr_out,
  output logic [7:0]                io_wdata_out,
  output logic                      set_io_bit_instr_out,
  output logic                      clear_io_bit_instr_out,
  output logic                      skip_if_io_bit_high_out,
  output logic                      skip_if_io_bit_low_out,
  output logic [2:0]                bit_sel_out,
  // Answers
  input  wire logic [7:0]           rd_data_in,
  input  wire logic                 rd_valid_in,
  input  wire logic                 skip_in,
  input  wire logic                 skip_valid_in
);
  // Idle bus at time zero
  initial
  begin
    {ds_rd_out, ds_wr_out, io_rd_out, io_wr_out} = 4'h0;
    {set_io_bit_instr_out, clear_io_bit_instr_out, skip_if_io_bit_high_out, skip_if_io_bit_low_out} = 4'h0;
    {ds_addr_out, ds_wdata_out, io_wdata_out, io_addr_out, bit_sel_out} = 33'h0;
  end

  // Kind: 0 load, 1 store, 2 in, 3 out, 4 set, 5 clear, 6 skip high, 7 skip low
  task automatic acc(input int kind, input logic [7:0] adr, input logic [7:0] dat, input logic [2:0] bsel,
                     output logic vld, output logic [7:0] got);
    @(negedge clk_in);
    ds_addr_out = adr;
    io_addr_out = adr[5:0];
    ds_wdata_out = dat; // Mapped places only, spare bits zero
    io_wdata_out = dat;
    bit_sel_out = bsel;
    {ds_rd_out, ds_wr_out, io_rd_out, io_wr_out} = {kind == 0, kind == 1, kind == 2, kind == 3};
    set_io_bit_instr_out = (kind == 4);
    clear_io_bit_instr_out = (kind == 5);
    skip_if_io_bit_high_out = (kind == 6);
    skip_if_io_bit_low_out = (kind == 7);
    @(negedge clk_in);
    {ds_rd_out, ds_wr_out, io_rd_out, io_wr_out} = 4'h0;
    {set_io_bit_instr_out, clear_io_bit_instr_out, skip_if_io_bit_high_out, skip_if_io_bit_low_out} = 4'h0;
    // Released lines show the inverse so no stale value can pass for a hold
    ds_addr_out = ~ds_addr_out;
    ds_wdata_out = ~ds_wdata_out;
    io_wdata_out = ~io_wdata_out;
    vld = (kind >= 6) ? skip_valid_in : rd_valid_in;
    got = (kind >= 6) ? {7'h00, skip_in} : rd_data_in;
  endtask
endmodule

// ===== dv/tb_iod_io_space.sv
`timescale 1ns/1ps
// ==================================================
// Bench for the I/O space decoder
// ==================================================
module tb_iod_io_space
  import iod_pkg::*;
  ;
  logic                 clk_in = 1'b0;
  logic                 rst_n_in = 1'b0;
  logic [7:0]           ds_addr_in, ds_wdata_in, io_wdata_in, rd_data_out, port_a_pins_in, port_b_pins_in;
  logic [7:0]           port_a_output_out, port_a_direction_out, port_b_output_out, port_b_direction_out;
  logic [7:0]           timer0_count_out, timer0_compare_a_out, timer0_compare_b_out, eeprom_data_out;
  logic [7:0]           debug_channel_out, two_wire_data_reg_out, two_wire_rate_reg_out;
  logic                 ds_rd_in, ds_wr_in, io_rd_in, io_wr_in, set_io_bit_instr_in, clear_io_bit_instr_in;
  logic                 skip_if_io_bit_high_in, skip_if_io_bit_low_in, rd_valid_out, skip_out, skip_valid_out;
  logic                 port_c_output_out;
  logic [IO_ADDR_W-1:0] io_addr_in;
  logic [2:0]           bit_sel_in, timer0_flag_set_in;
  logic [1:0]           port_d_pins_in, timer1_flag_set_in, pin_change_flag_set_in;
  logic [1:0]           port_d_output_out, port_d_direction_out;
  logic [3:0]           external_int_flag_set_in, external_int_mask_out;
  logic [15:0]          timer1_count_in, timer1_compare_out;
  logic [11:0]          voltage_converter_result_in;
  logic [8:0]           eeprom_address_out;
  int                   num_errors = 0;
  int                   n_checks = 0;
  int                   cyc = 0;
  logic                 v;
  logic [7:0]           g;
  // Location and implemented-bit mask
  localparam logic [15:0] MAP [17] = '{16'h47FF, 16'h48FF, 16'h46FF, 16'h88FF, 16'h89FF, 16'hBBFF, 16'hB8FF,
    16'h51FF, 16'h3EFF, 16'h4AFF, 16'h4BFF, 16'h40FF, 16'h41FF, 16'h4201, 16'h3D0F, 16'h6E07, 16'h60FF};
  localparam logic [7:0]  SCR = 8'h9F;

  iod_io_space dut_u (.*);
  iod_cpu_model cpu_u (.clk_in(clk_in), .ds_addr_out(ds_addr_in), .ds_rd_out(ds_rd_in), .ds_wr_out(ds_wr_in),
    .ds_wdata_out(ds_wdata_in), .io_addr_out(io_addr_in), .io_rd_out(io_rd_in), .io_wr_out(io_wr_in),
    .io_wdata_out(io_wdata_in), .set_io_bit_instr_out(set_io_bit_instr_in),
    .clear_io_bit_instr_out(clear_io_bit_instr_in), .skip_if_io_bit_high_out(skip_if_io_bit_high_in),
    .skip_if_io_bit_low_out(skip_if_io_bit_low_in), .bit_sel_out(bit_sel_in), .rd_data_in(rd_data_out),
    .rd_valid_in(rd_valid_out), .skip_in(skip_out), .skip_valid_in(skip_valid_out));

  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;

  // Ceiling far above the few hundred cycles needed
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      $display("BAD %0t run timed out", $time);
      final_report();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd(input int k, input logic [7:0] a, input logic [7:0] e);
    cpu_u.acc(k, a, 8'h00, 3'h0, v, g);
    chk_bit(v, 1'b1);
    chk_byte(g, e);
  endtask
  task automatic wr(input int k, input logic [7:0] a, input logic [7:0] d, input logic [2:0] b);
    cpu_u.acc(k, a, d, b, v, g);
  endtask
  task automatic sk(input int k, input logic [7:0] a, input logic [2:0] b, input logic ev, input logic e);
    cpu_u.acc(k, a, 8'h00, b, v, g);
    chk_bit(v, ev);
    if (ev)
      chk_bit(g[0], e);
  endtask
  task automatic tdone(input string name);
    $display("test %s done, errors %0d", name, num_errors);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {port_a_pins_in, port_b_pins_in, port_d_pins_in} = {8'h3C, 8'hC3, 2'h2};
    {timer0_flag_set_in, timer1_flag_set_in, pin_change_flag_set_in, external_int_flag_set_in} = 11'h000;
    timer1_count_in = 16'h1234;
    voltage_converter_result_in = 12'hABC;
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    foreach (MAP[i]) rd(0, MAP[i][15:8], REG_RST);
    foreach (MAP[i]) wr(1, MAP[i][15:8], (MAP[i][15:8] ^ 8'hA5) & MAP[i][7:0], 3'h0);
    foreach (MAP[i]) rd(0, MAP[i][15:8], (MAP[i][15:8] ^ 8'hA5) & MAP[i][7:0]);
    chk_byte(timer1_compare_out[15:8], 8'h2C);
    chk_byte(timer1_compare_out[7:0], 8'h2D);
    chk_byte(two_wire_data_reg_out, 8'h1E);
    chk_byte(two_wire_rate_reg_out, 8'h1D);
    chk_byte(debug_channel_out, 8'hF4);
    chk_byte(eeprom_address_out[7:0], 8'hE4);
    chk_bit(eeprom_address_out[8], 1'b1);
    chk_byte(timer0_compare_a_out, 8'hE2);
    chk_byte(timer0_count_out, 8'hE3);
    tdone("map");
    wr(3, 8'h02, 8'h96, 3'h0);
    rd(0, 8'h22, 8'h96);
    chk_byte(port_a_output_out, 8'h96);
    rd(2, 8'h27, 8'hE2);
    rd(2, 8'h00, 8'h3C);
    rd(0, 8'h23, 8'hC3);
    rd(0, 8'h29, 8'h02);
    wr(3, 8'h20, 8'h11, 3'h0);
    rd(0, 8'h60, 8'hC5);
    rd(0, 8'h40, 8'h11);
    chk_byte(eeprom_data_out, 8'h11);
    tdone("io space");
    @(negedge clk_in);
    {timer0_flag_set_in, timer1_flag_set_in, pin_change_flag_set_in, external_int_flag_set_in} = 11'h7FF;
    @(negedge clk_in);
    {timer0_flag_set_in, timer1_flag_set_in, pin_change_flag_set_in, external_int_flag_set_in} = 11'h000;
    rd(0, 8'h35, 8'h07);
    rd(0, 8'h36, 8'h03);
    rd(0, 8'h3B, 8'h03);
    wr(1, 8'h35, 8'h02, 3'h0);
    rd(0, 8'h35, 8'h05);
    wr(1, 8'h35, 8'h00, 3'h0);
    rd(0, 8'h35, 8'h05);
    wr(4, 8'h15, 8'h00, 3'h0);
    rd(0, 8'h35, 8'h00);
    wr(5, 8'h1C, 8'h00, 3'h0);
    rd(0, 8'h3C, 8'h01);
    tdone("flags");
    wr(5, 8'h22, 8'h00, 3'h0);
    rd(0, 8'h42, 8'h01);
    wr(4, 8'h1E, 8'h00, 3'h2);
    rd(0, 8'h3E, SCR);
    sk(6, 8'h22, 3'h0, 1'b0, 1'b0);
    for (int b = 0; b < 8; b++)
    begin
      sk(6, 8'h1E, 3'(b), 1'b1, SCR[b]);
      sk(7, 8'h1E, 3'(b), 1'b1, !SCR[b]);
    end
    tdone("bit ops");
    rd(0, 8'h85, 8'h12);
    rd(0, 8'h84, 8'h34);
    rd(0, 8'h79, 8'h0A);
    rd(0, 8'h78, 8'hBC);
    rd(0, 8'h7A, 8'h00);
    rd(0, 8'hB9, 8'h00);
    @(negedge clk_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    rd(0, 8'h47, REG_RST);
    rd(0, 8'h3C, REG_RST);
    tdone("read only and reset");
    final_report();
  end
endmodule
